// ---- rtl/drpm_top.v ----
// large dual-port memory block with Avalon-MM configuration slave
// assumes both user ports and the bus master run on clk_i
//
// Our own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "drpm_defs.vh"

module drpm_top (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // port A
  input wire clr_a_i,
  input wire en_a_i,
  input wire we_a_i,
  input wire [`DRPM_ADDR_W-1:0] addr_a_i,
  input wire [`DRPM_PORT_W-1:0] din_a_i,
  input wire [`DRPM_PORT_BE-1:0] be_a_i,
  output reg [`DRPM_PORT_W-1:0] dout_a_o,
  output reg valid_a_o,
  // port B
  input wire clr_b_i,
  input wire en_b_i,
  input wire we_b_i,
  input wire [`DRPM_ADDR_W-1:0] addr_b_i,
  input wire [`DRPM_PORT_W-1:0] din_b_i,
  input wire [`DRPM_PORT_BE-1:0] be_b_i,
  output reg [`DRPM_PORT_W-1:0] dout_b_o,
  output reg valid_b_o,
  // fifo flags
  output reg fifo_empty_o,
  output reg fifo_full_o,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o
);

  // ****************************************************
  // lane helpers
  // ****************************************************
  // first storage lane touched by an access of width code w
  function [3:0] lane_base;
    input [2:0] w;
    input [`DRPM_ADDR_W-1:0] a;
    begin
      case (w)
        `DRPM_W9: lane_base = a[3:0];
        `DRPM_W18: lane_base = {a[2:0], 1'b0};
        `DRPM_W36: lane_base = {a[1:0], 2'b00};
        `DRPM_W72: lane_base = {a[0], 3'b000};
        default: lane_base = 4'h0;
      endcase
    end
  endfunction

  // row of the 144-bit array for width code w
  function [`DRPM_ROW_W-1:0] row_of;
    input [2:0] w;
    input [`DRPM_ADDR_W-1:0] a;
    begin
      case (w)
        `DRPM_W9: row_of = a[15:4];
        `DRPM_W18: row_of = a[14:3];
        `DRPM_W36: row_of = a[13:2];
        `DRPM_W72: row_of = a[12:1];
        default: row_of = a[11:0];
      endcase
    end
  endfunction

  // spread user data onto storage lanes; 8-bit bytes leave bit 8 zero
  function [`DRPM_WIDE_W-1:0] place_data;
    input [2:0] w;
    input [3:0] base;
    input [`DRPM_WIDE_W-1:0] din;
    input par;
    integer k;
    begin
      place_data = {`DRPM_WIDE_W{1'b0}};
      for (k = 0; k < `DRPM_LANES; k = k + 1) begin
        if (k < (1 << w)) begin
          if (par) begin
            place_data[`DRPM_LANE_W*(base+k) +: `DRPM_LANE_W] =
              din[`DRPM_LANE_W*k +: `DRPM_LANE_W];
          end else begin // byte k sits in the low bits
            place_data[`DRPM_LANE_W*(base+k) +: `DRPM_LANE_W] =
              {1'b0, din[`DRPM_BYTE_W*k +: `DRPM_BYTE_W]};
          end
        end
      end
    end
  endfunction

  // per-lane write mask; the narrowest shape has no mask
  function [`DRPM_LANES-1:0] place_mask;
    input [2:0] w;
    input [3:0] base;
    input [`DRPM_LANES-1:0] be;
    integer k;
    begin
      place_mask = {`DRPM_LANES{1'b0}};
      for (k = 0; k < `DRPM_LANES; k = k + 1) begin
        if (k < (1 << w)) begin
          place_mask[base+k] = (w == `DRPM_W9) ? 1'b1 : be[k];
        end
      end
    end
  endfunction

  // gather lanes of a stored row back into user order
  function [`DRPM_WIDE_W-1:0] pick_data;
    input [2:0] w;
    input [3:0] base;
    input [`DRPM_WIDE_W-1:0] word;
    input par;
    integer k;
    reg [`DRPM_LANE_W-1:0] ln;
    begin
      pick_data = {`DRPM_WIDE_W{1'b0}};
      ln = {`DRPM_LANE_W{1'b0}};
      for (k = 0; k < `DRPM_LANES; k = k + 1) begin
        if (k < (1 << w)) begin
          ln = word[`DRPM_LANE_W*(base+k) +: `DRPM_LANE_W];
          if (par) begin
            pick_data[`DRPM_LANE_W*k +: `DRPM_LANE_W] = ln;
          end else begin
            pick_data[`DRPM_BYTE_W*k +: `DRPM_BYTE_W] =
              ln[`DRPM_BYTE_W-1:0];
          end
        end
      end
    end
  endfunction

  // ****************************************************
  // declarations
  // ****************************************************
  reg [`DRPM_CTRL_W-1:0] ctrl;
  reg cfg_err;
  reg [`DRPM_CNT_W-1:0] fifo_cnt;
  reg [`DRPM_ADDR_W-1:0] wptr;
  reg [`DRPM_ADDR_W-1:0] rptr;
  reg [`DRPM_WIDE_W-1:0] mem [0:`DRPM_ROWS-1];
  reg [`DRPM_PORT_W-1:0] hold_a;
  reg [`DRPM_PORT_W-1:0] hold_b;
  reg hold_v_a;
  reg hold_v_b;
  reg ctrl_wr;
  reg [`DRPM_CNT_W-1:0] next_cnt;
  wire ien_a, iwe_a, ien_b, iwe_b;
  wire [`DRPM_ADDR_W-1:0] iaddr_a, iaddr_b;
  wire [`DRPM_PORT_W-1:0] idin_a, idin_b;
  wire [`DRPM_PORT_BE-1:0] ibe_a, ibe_b;
  wire [1:0] mode = ctrl[`DRPM_F_MODE];
  wire [2:0] wid_a = ctrl[`DRPM_F_WID_A];
  wire [2:0] wid_b_raw = ctrl[`DRPM_F_WID_B];
  wire par = ctrl[`DRPM_B_PARITY];
  wire is_fifo = (mode == `DRPM_MODE_FIFO);
  wire wide = (wid_a == `DRPM_W144); // joint 144-bit path
  wire [2:0] wid_b = is_fifo ? wid_a : wid_b_raw;
  wire [`DRPM_CNT_W-1:0] depth = `DRPM_FULL_DEPTH >> wid_a;

  // ****************************************************
  // input stages, one per port
  // ****************************************************
  // same clock for both stages; each has its own clear
  drpm_port_in u_in_a (
    .clk_i(clk_i), .rst_i(rst_i), .clr_i(clr_a_i),
    .en_i(en_a_i), .we_i(we_a_i), .addr_i(addr_a_i),
    .din_i(din_a_i), .be_i(be_a_i),
    .en_o(ien_a), .we_o(iwe_a), .addr_o(iaddr_a),
    .din_o(idin_a), .be_o(ibe_a)
  );

  drpm_port_in u_in_b (
    .clk_i(clk_i), .rst_i(rst_i), .clr_i(clr_b_i),
    .en_i(en_b_i), .we_i(we_b_i), .addr_i(addr_b_i),
    .din_i(din_b_i), .be_i(be_b_i),
    .en_o(ien_b), .we_o(iwe_b), .addr_o(iaddr_b),
    .din_o(idin_b), .be_o(ibe_b)
  );

  // ****************************************************
  // configuration check
  // ****************************************************
  // an illegal shape blocks every access until software fixes it
  always @* begin
    cfg_err = (wid_a > `DRPM_W144) || (wid_b_raw > `DRPM_W144);
    case (mode)
      `DRPM_MODE_TDP: cfg_err = cfg_err || wide ||
        (wid_b_raw == `DRPM_W144);
      `DRPM_MODE_SDP: cfg_err = cfg_err ||
        (wide != (wid_b_raw == `DRPM_W144));
      `DRPM_MODE_SP: cfg_err = cfg_err || wide;
      `DRPM_MODE_FIFO: cfg_err = cfg_err || wide;
      default: cfg_err = 1'b1;
    endcase
  end

  // ****************************************************
  // access decode
  // ****************************************************
  // write enable alone chooses the direction
  wire ok = !cfg_err;
  wire full_now = (fifo_cnt == depth);
  wire empty_now = (fifo_cnt == {`DRPM_CNT_W{1'b0}});
  wire push = ok && is_fifo && ien_a && iwe_a && !full_now;
  wire pop = ok && is_fifo && ien_b && !iwe_b && !empty_now;
  wire wr_a = ok && ien_a && iwe_a &&
    (is_fifo ? !full_now : 1'b1);
  wire rd_a = ok && ien_a && !iwe_a && !is_fifo &&
    (mode != `DRPM_MODE_SDP); // write side only
  wire wr_b = ok && ien_b && iwe_b &&
    (mode == `DRPM_MODE_TDP);
  wire rd_b = ok && ien_b && !iwe_b &&
    (mode != `DRPM_MODE_SP) && (is_fifo ? !empty_now : 1'b1);
  wire [`DRPM_ADDR_W-1:0] ea_a = is_fifo ? wptr : iaddr_a;
  wire [`DRPM_ADDR_W-1:0] ea_b = is_fifo ? rptr : iaddr_b;
  wire [3:0] base_a = lane_base(wid_a, ea_a);
  wire [3:0] base_b = lane_base(wid_b, ea_b);
  wire [`DRPM_ROW_W-1:0] row_a = row_of(wid_a, ea_a);
  wire [`DRPM_ROW_W-1:0] row_b = row_of(wid_b, ea_b);
  // 144-bit writes join both data paths and both masks
  wire [`DRPM_WIDE_W-1:0] wdin_a = wide ? {idin_b, idin_a} :
    {{`DRPM_PORT_W{1'b0}}, idin_a};
  wire [`DRPM_LANES-1:0] wbe_a = wide ? {ibe_b, ibe_a} :
    {{`DRPM_PORT_BE{1'b0}}, ibe_a};
  wire [`DRPM_WIDE_W-1:0] lane_d_a = place_data(wid_a, base_a, wdin_a, par);
  wire [`DRPM_WIDE_W-1:0] lane_d_b = place_data(wid_b, base_b,
    {{`DRPM_PORT_W{1'b0}}, idin_b}, par);
  wire [`DRPM_LANES-1:0] lane_m_a = place_mask(wid_a, base_a, wbe_a);
  wire [`DRPM_LANES-1:0] lane_m_b = place_mask(wid_b, base_b,
    {{`DRPM_PORT_BE{1'b0}}, ibe_b});
  wire [`DRPM_WIDE_W-1:0] rdw_a = pick_data(wid_a, base_a, mem[row_a], par);
  wire [`DRPM_WIDE_W-1:0] rdw_b = pick_data(wid_b, base_b, mem[row_b], par);

  // ****************************************************
  // storage array
  // ****************************************************
  // no reset and no preload: contents start undefined
  // one process owns the array; on a lane clash port B lands last
  integer i;
  always @(posedge clk_i) begin
    for (i = 0; i < `DRPM_LANES; i = i + 1) begin
      if (wr_a && lane_m_a[i]) begin // masked lanes untouched
        mem[row_a][`DRPM_LANE_W*i +: `DRPM_LANE_W] <=
          lane_d_a[`DRPM_LANE_W*i +: `DRPM_LANE_W];
      end
      if (wr_b && lane_m_b[i]) begin
        mem[row_b][`DRPM_LANE_W*i +: `DRPM_LANE_W] <=
          lane_d_b[`DRPM_LANE_W*i +: `DRPM_LANE_W];
      end
    end
  end

  // ****************************************************
  // read paths
  // ****************************************************
  // 144-bit reads come off port B's address, split over both outputs
  wire src_v_a = wide ? rd_b : rd_a;
  wire [`DRPM_PORT_W-1:0] src_d_a = wide ?
    rdw_b[`DRPM_PORT_W-1:0] : rdw_a[`DRPM_PORT_W-1:0];
  wire [`DRPM_PORT_W-1:0] src_d_b = wide ?
    rdw_b[`DRPM_WIDE_W-1:`DRPM_PORT_W] : rdw_b[`DRPM_PORT_W-1:0];

  // port A output stage; the output register trades a cycle for timing slack
  always @(posedge clk_i or posedge clr_a_i) begin
    if (clr_a_i) begin
      hold_a <= {`DRPM_PORT_W{1'b0}};
      hold_v_a <= 1'b0;
      dout_a_o <= {`DRPM_PORT_W{1'b0}};
      valid_a_o <= 1'b0;
    end else if (rst_i) begin
      hold_a <= {`DRPM_PORT_W{1'b0}};
      hold_v_a <= 1'b0;
      dout_a_o <= {`DRPM_PORT_W{1'b0}};
      valid_a_o <= 1'b0;
    end else begin
      hold_v_a <= src_v_a;
      if (src_v_a) begin
        hold_a <= src_d_a;
      end
      if (!ctrl[`DRPM_B_OREG_A]) begin // bypassed
        valid_a_o <= src_v_a;
        if (src_v_a) begin
          dout_a_o <= src_d_a;
        end
      end else begin
        valid_a_o <= hold_v_a;
        if (hold_v_a) begin
          dout_a_o <= hold_a;
        end
      end
    end
  end

  // port B output stage, same shape as port A
  always @(posedge clk_i or posedge clr_b_i) begin
    if (clr_b_i) begin
      hold_b <= {`DRPM_PORT_W{1'b0}};
      hold_v_b <= 1'b0;
      dout_b_o <= {`DRPM_PORT_W{1'b0}};
      valid_b_o <= 1'b0;
    end else if (rst_i) begin
      hold_b <= {`DRPM_PORT_W{1'b0}};
      hold_v_b <= 1'b0;
      dout_b_o <= {`DRPM_PORT_W{1'b0}};
      valid_b_o <= 1'b0;
    end else begin
      hold_v_b <= rd_b;
      if (rd_b) begin
        hold_b <= src_d_b;
      end
      if (!ctrl[`DRPM_B_OREG_B]) begin // bypassed
        valid_b_o <= rd_b;
        if (rd_b) begin
          dout_b_o <= src_d_b;
        end
      end else begin
        valid_b_o <= hold_v_b;
        if (hold_v_b) begin
          dout_b_o <= hold_b;
        end
      end
    end
  end

  // ****************************************************
  // fifo pointers
  // ****************************************************
  // a config write restarts the queue, since depth may change
  always @* begin
    next_cnt = fifo_cnt;
    if (push && !pop) begin
      next_cnt = fifo_cnt + 1'b1;
    end else if (pop && !push) begin
      next_cnt = fifo_cnt - 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || ctrl_wr) begin
      wptr <= {`DRPM_ADDR_W{1'b0}};
      rptr <= {`DRPM_ADDR_W{1'b0}};
      fifo_cnt <= {`DRPM_CNT_W{1'b0}};
      fifo_empty_o <= 1'b1;
      fifo_full_o <= 1'b0;
    end else begin
      if (push) begin // wraps at depth
        wptr <= (wptr == depth[`DRPM_ADDR_W-1:0] - 1'b1) ?
          {`DRPM_ADDR_W{1'b0}} : wptr + 1'b1;
      end
      if (pop) begin
        rptr <= (rptr == depth[`DRPM_ADDR_W-1:0] - 1'b1) ?
          {`DRPM_ADDR_W{1'b0}} : rptr + 1'b1;
      end
      fifo_cnt <= next_cnt;
      fifo_empty_o <= (next_cnt == {`DRPM_CNT_W{1'b0}});
      fifo_full_o <= (next_cnt == depth);
    end
  end

  // ****************************************************
  // avalon-mm slave
  // ****************************************************
  // two edges per transfer: first drops waitrequest, second completes
  always @* begin
    ctrl_wr = avs_write_i && !avs_waitrequest_o &&
      (avs_address_i == `DRPM_REG_CTRL);
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
      ctrl <= `DRPM_CTRL_RST;
    end else begin
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        avs_readdata_o <= 32'h0000_0000; // unmapped reads zero
        if (avs_read_i && avs_address_i == `DRPM_REG_CTRL) begin
          avs_readdata_o[`DRPM_CTRL_W-1:0] <= ctrl;
        end else if (avs_read_i && avs_address_i == `DRPM_REG_STAT) begin
          avs_readdata_o[`DRPM_B_ERR] <= cfg_err;
          avs_readdata_o[`DRPM_B_EMPTY] <= fifo_empty_o;
          avs_readdata_o[`DRPM_B_FULL] <= fifo_full_o;
          avs_readdata_o[`DRPM_F_COUNT] <= fifo_cnt;
        end
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
      // byte lanes 0 and 1 carry the control fields
      if (ctrl_wr && avs_byteenable_i[0]) begin
        ctrl[`DRPM_F_CTRL_LO] <= avs_writedata_i[`DRPM_F_CTRL_LO];
      end
      if (ctrl_wr && avs_byteenable_i[1]) begin
        ctrl[`DRPM_F_CTRL_HI] <= avs_writedata_i[`DRPM_F_CTRL_HI];
      end
    end
  end

endmodule // drpm_top

// ---- rtl/drpm_defs.vh ----
// constants shared by the large dual-port memory block
// assumes byte-addressed 32-bit Avalon-MM register access
`ifndef DRPM_DEFS_VH
`define DRPM_DEFS_VH

// ****************************************************
// storage geometry
// ****************************************************
`define DRPM_ROWS 4096
`define DRPM_ROW_W 12
`define DRPM_ADDR_W 16
`define DRPM_LANES 16
`define DRPM_LANE_W 9
`define DRPM_BYTE_W 8
`define DRPM_PORT_W 72
`define DRPM_PORT_BE 8
`define DRPM_WIDE_W 144
`define DRPM_CNT_W 17
`define DRPM_FULL_DEPTH 17'h1_0000

// ****************************************************
// modes and width codes
// ****************************************************
`define DRPM_MODE_TDP 2'h0
`define DRPM_MODE_SDP 2'h1
`define DRPM_MODE_SP 2'h2
`define DRPM_MODE_FIFO 2'h3
`define DRPM_W9 3'h0
`define DRPM_W18 3'h1
`define DRPM_W36 3'h2
`define DRPM_W72 3'h3
`define DRPM_W144 3'h4

// ****************************************************
// register map
// ****************************************************
`define DRPM_REG_CTRL 4'h0
`define DRPM_REG_STAT 4'h4
`define DRPM_CTRL_W 11
`define DRPM_CTRL_RST 11'h76C
`define DRPM_F_MODE 1:0
`define DRPM_F_WID_A 4:2
`define DRPM_F_WID_B 7:5
`define DRPM_B_OREG_A 8
`define DRPM_B_OREG_B 9
`define DRPM_B_PARITY 10
`define DRPM_F_CTRL_LO 7:0
`define DRPM_F_CTRL_HI 10:8
`define DRPM_F_BUS_HI 2:0
`define DRPM_B_ERR 0
`define DRPM_B_EMPTY 1
`define DRPM_B_FULL 2
`define DRPM_F_COUNT 24:8

`endif

// ---- rtl/drpm_port_in.v ----
// input capture stage for one memory port
// assumes user logic on clk_i; clear is asynchronous, active high
`timescale 1ns/1ps
`include "drpm_defs.vh"

module drpm_port_in #(
  parameter AW = `DRPM_ADDR_W,
  parameter DW = `DRPM_PORT_W,
  parameter BW = `DRPM_PORT_BE
) (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire clr_i,
  // raw port controls
  input wire en_i,
  input wire we_i,
  input wire [AW-1:0] addr_i,
  input wire [DW-1:0] din_i,
  input wire [BW-1:0] be_i,
  // captured values
  output reg en_o,
  output reg we_o,
  output reg [AW-1:0] addr_o,
  output reg [DW-1:0] din_o,
  output reg [BW-1:0] be_o
);

  // ****************************************************
  // capture registers
  // ****************************************************
  // every input is registered before the array sees it
  // clear acts at once, without an edge
  always @(posedge clk_i or posedge clr_i) begin
    if (clr_i) begin
      en_o <= 1'b0;
      we_o <= 1'b0;
      addr_o <= {AW{1'b0}};
      din_o <= {DW{1'b0}};
      be_o <= {BW{1'b0}};
    end else if (rst_i) begin
      en_o <= 1'b0;
      we_o <= 1'b0;
      addr_o <= {AW{1'b0}};
      din_o <= {DW{1'b0}};
      be_o <= {BW{1'b0}};
    end else begin
      en_o <= en_i; // strobe marks a fresh access
      if (en_i) begin // held values while the enable is low
        we_o <= we_i;
        addr_o <= addr_i;
        din_o <= din_i;
        be_o <= be_i;
      end
    end
  end

endmodule // drpm_port_in

// ---- tb/drpm_top_monitor.sv ----
// checker on the ports of the large dual-port memory block
// assumes bind into drpm_top, one clock, synchronous reset
`timescale 1ns/1ps
`include "drpm_defs.vh"

module drpm_top_monitor (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // port a
  input wire clr_a_i,
  input wire en_a_i,
  input wire we_a_i,
  input wire [`DRPM_PORT_W-1:0] dout_a_o,
  input wire valid_a_o,
  // port b
  input wire clr_b_i,
  input wire en_b_i,
  input wire we_b_i,
  input wire [`DRPM_PORT_W-1:0] dout_b_o,
  input wire valid_b_o,
  // register bus
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire avs_waitrequest_o
);
  // ****************************************************
  // shadow of the control word
  // ****************************************************
  reg [10:0] ctrl;
  wire tdp;
  wire rd_a;
  wire rd_b;

  // follows completed bus writes, byte lanes 0 and 1 only
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `DRPM_CTRL_RST;
    end else if (avs_write_i && !avs_waitrequest_o &&
                 avs_address_i == `DRPM_REG_CTRL) begin
      if (avs_byteenable_i[0]) ctrl[7:0] <= avs_writedata_i[7:0];
      if (avs_byteenable_i[1]) ctrl[10:8] <= avs_writedata_i[10:8];
    end
  end

  // latency only judged in a legal true dual-port setup
  assign tdp = ctrl[1:0] == `DRPM_MODE_TDP && ctrl[4:2] < 3'h4 &&
               ctrl[7:5] < 3'h4;
  assign rd_a = en_a_i && !we_a_i && !clr_a_i && tdp;
  assign rd_b = en_b_i && !we_b_i && !clr_b_i && tdp;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************************
  // assertions
  // ****************************************************
  property p_lat_a;
    rd_a && !ctrl[8] |-> ##2 valid_a_o;
  endproperty
  a_lat_a: assert property (p_lat_a) else $error("a read late");
  property p_lat_ao;
    rd_a && ctrl[8] |-> ##2 !valid_a_o ##1 valid_a_o;
  endproperty
  a_lat_ao: assert property (p_lat_ao) else $error("a reg read");
  property p_lat_b;
    rd_b && !ctrl[9] |-> ##2 valid_b_o;
  endproperty
  a_lat_b: assert property (p_lat_b) else $error("b read late");
  property p_wr_a;
    en_a_i && we_a_i |=> !valid_a_o [*3];
  endproperty
  a_wr_a: assert property (p_wr_a) else $error("a write gave data");
  property p_clr_a;
    clr_a_i |-> dout_a_o == 0 && !valid_a_o;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("a clear slow");
  property p_clr_b;
    clr_b_i |-> dout_b_o == 0 && !valid_b_o;
  endproperty
  a_clr_b: assert property (p_clr_b) else $error("b clear slow");
  property p_hold_a;
    !valid_a_o && !clr_a_i && !$past(clr_a_i) |-> $stable(dout_a_o);
  endproperty
  a_hold_a: assert property (p_hold_a) else $error("a data moved");
  property p_wr_b;
    en_b_i && we_b_i |=> !valid_b_o [*3];
  endproperty
  a_wr_b: assert property (p_wr_b) else $error("b write gave data");
  property p_bus;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait wrong");
endmodule // drpm_top_monitor

bind drpm_top drpm_top_monitor i_mon (
  .clk_i, .rst_i, .clr_a_i, .en_a_i, .we_a_i, .dout_a_o, .valid_a_o,
  .clr_b_i, .en_b_i, .we_b_i, .dout_b_o, .valid_b_o, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
  .avs_waitrequest_o
);

// ---- tb/drpm_user_model.sv ----
// user logic driving one memory port of the block
// assumes the block captures the port on the edge after setup
`timescale 1ns/1ps

module drpm_user_model (
  // clock and returned data
  input wire clk_i,
  input wire valid_i,
  input wire [71:0] dout_i,
  // port controls
  output logic en_o,
  output logic we_o,
  output logic [15:0] addr_o,
  output logic [71:0] din_o,
  output logic [7:0] be_o
);
  // idle port at time zero
  initial begin
    en_o = 1'b0;
    we_o = 1'b0;
    addr_o = 16'h0000;
    din_o = 72'h0;
    be_o = 8'hFF;
  end

  // one access; idles four edges so results never overlap
  task acc(input logic e, input logic w, input logic [15:0] a,
           input logic [71:0] d, input logic [7:0] b,
           output logic [71:0] q, output integer lat);
    integer n;
    begin
      @(posedge clk_i);
      en_o <= e;
      we_o <= w;
      addr_o <= a;
      din_o <= d;
      be_o <= b;
      @(posedge clk_i);
      // released address and data lines carry junk, not the old value; we and be keep theirs
      en_o <= 1'b0;
      addr_o <= ~a;
      din_o <= ~d;
      lat = 0;
      q = {72{1'bx}};
      for (n = 1; n <= 4; n = n + 1) begin
        @(posedge clk_i);
        if (valid_i === 1'b1 && lat == 0) begin
          lat = n;
          q = dout_i;
        end
      end
    end
  endtask
endmodule // drpm_user_model

// ---- tb/drpm_top_test.sv ----
// self-checking bench for the large dual-port memory block
// assumes drpm_top, its monitor and two user port models
`timescale 1ns/1ps

module drpm_top_test;
  logic clk_i, rst_i, clr_a_i, clr_b_i, en_a_i, we_a_i, en_b_i, we_b_i;
  logic [15:0] addr_a_i, addr_b_i;
  logic [71:0] din_a_i, din_b_i, dout_a_o, dout_b_o, qa, qb;
  logic [7:0] be_a_i, be_b_i;
  logic valid_a_o, valid_b_o, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic fe, ff;
  logic [3:0] avs_address_i, avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rq;
  logic [143:0] m;
  logic [10:0] cfg [8] = '{11'h490, 11'h491, 11'h411, 11'h461,
                           11'h46E, 11'h42F, 11'h41C, 11'h46C};
  logic [7:0] bad = 8'h45;
  integer la, lb, i, errors, checked;

  drpm_top i_dut (.clk_i, .rst_i, .clr_a_i, .en_a_i, .we_a_i, .addr_a_i,
    .din_a_i, .be_a_i, .dout_a_o, .valid_a_o, .clr_b_i, .en_b_i, .we_b_i,
    .addr_b_i, .din_b_i, .be_b_i, .dout_b_o, .valid_b_o,
    .fifo_empty_o(fe), .fifo_full_o(ff), .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o);
  drpm_user_model i_ua (.clk_i, .valid_i(valid_a_o), .dout_i(dout_a_o),
    .en_o(en_a_i), .we_o(we_a_i), .addr_o(addr_a_i), .din_o(din_a_i),
    .be_o(be_a_i));
  drpm_user_model i_ub (.clk_i, .valid_i(valid_b_o), .dout_i(dout_b_o),
    .en_o(en_b_i), .we_o(we_b_i), .addr_o(addr_b_i), .din_o(din_b_i),
    .be_o(be_b_i));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ****************************************************
  // helpers
  // ****************************************************
  // lane k holds s+k, so a misplaced lane shows
  function automatic logic [71:0] pat(input logic [8:0] s);
    for (int k = 0; k < 8; k++) pat[9*k+:9] = s + k[8:0];
  endfunction
  function automatic logic [143:0] mrg(input logic [143:0] o,
      input logic [143:0] n, input logic [15:0] b);
    for (int k = 0; k < 16; k++) mrg[9*k+:9] = b[k] ? n[9*k+:9] : o[9*k+:9];
  endfunction
  task chk(input string s, input logic [143:0] e, input logic [143:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("MISMATCH %0s exp %h got %h", s, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  // one bus transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d,
           input logic [3:0] b, output logic [31:0] q);
    integer n;
    logic wt;
    begin
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= b;
      avs_write_i <= w;
      avs_read_i <= !w;
      n = 0;
      do begin
        @(posedge clk_i);
        wt = avs_waitrequest_o;
        n = n + 1;
      end while (wt !== 1'b0 && n < 16);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      if (wt !== 1'b0) begin
        chk("waitrequest", 0, 1);
        results;
      end
    end
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000, 4'hF, rq);
      chk("register", e, rq);
    end
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    errors = 0;
    checked = 0;
    rst_i = 1'b1;
    clr_a_i = 1'b0;
    clr_b_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0000_0000;
    avs_byteenable_i = 4'hF;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(4'h0, 32'h0000_076C);
    rd(4'h4, 32'h0000_0002);
    bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF, rq);
    rd(4'h8, 32'h0000_0000);
    rd(4'h0, 32'h0000_076C);
    $display("test registers done");
    // registered output on port B, then bypassed on port A
    i_ua.acc(1, 1, 16'h0005, pat(9'h0A0), 8'hFF, qa, la);
    i_ub.acc(1, 0, 16'h0005, 72'h0, 8'hFF, qb, lb);
    chk("dout_b", pat(9'h0A0), qb);
    chk("lat_b", 3, lb);
    bus(1'b1, 4'h0, 32'h0000_0400, 4'b0010, rq);
    rd(4'h0, 32'h0000_046C);
    i_ua.acc(1, 0, 16'h0005, 72'h0, 8'hFF, qa, la);
    chk("dout_a", pat(9'h0A0), qa);
    chk("lat_a", 2, la);
    $display("test latency done");
    // gapped mask, empty mask, read carrying data
    i_ua.acc(1, 1, 16'h0005, pat(9'h150), 8'hA5, qa, la);
    i_ub.acc(1, 1, 16'h0005, pat(9'h1F0), 8'h00, qb, lb);
    i_ub.acc(1, 0, 16'h0005, pat(9'h0F0), 8'hFF, qb, lb);
    m = mrg(pat(9'h0A0), pat(9'h150), 16'h00A5);
    chk("mask", m, qb);
    $display("test mask done");
    // 64-bit words, one mask bit per 8-bit byte
    bus(1'b1, 4'h0, 32'h0000_006C, 4'hF, rq);
    i_ua.acc(1, 1, 16'h0007, {8'h00, 64'h0123_4567_89AB_CDEF}, 8'hFF, qa, la);
    i_ua.acc(1, 1, 16'h0007, {8'h00, 64'hFFFF_FFFF_FFFF_FFFF}, 8'h24, qa, la);
    i_ub.acc(1, 0, 16'h0007, 72'h0, 8'hFF, qb, lb);
    chk("bytes", 64'h0123_FF67_89FF_CDEF, qb[63:0]);
    $display("test bytes done");
    // every mode, legal and refused shapes
    for (i = 0; i < 8; i = i + 1) begin
      bus(1'b1, 4'h0, {21'h0, cfg[i]}, 4'hF, rq);
      bus(1'b0, 4'h4, 32'h0000_0000, 4'hF, rq);
      chk("cfg_err", bad[i], rq[0]);
    end
    // one word through the fifo
    bus(1'b1, 4'h0, 32'h0000_042F, 4'hF, rq);
    i_ua.acc(1, 1, 16'h0000, pat(9'h033), 8'hFF, qa, la);
    chk("flags", 0, {ff, fe});
    i_ub.acc(1, 0, 16'h0000, 72'h0, 8'hFF, qb, lb);
    chk("fifo", pat(9'h033), qb);
    chk("flags", 1, {ff, fe});
    $display("test shapes done");
    // joined 144-bit word, 16 mask bits
    bus(1'b1, 4'h0, 32'h0000_0491, 4'hF, rq);
    fork
      i_ua.acc(1, 1, 16'h0003, pat(9'h011), 8'hFF, qa, la);
      i_ub.acc(1, 1, 16'h0003, pat(9'h111), 8'hFF, qb, lb);
    join
    fork
      i_ua.acc(1, 1, 16'h0003, pat(9'h022), 8'h00, qa, la);
      i_ub.acc(1, 1, 16'h0003, pat(9'h122), 8'h81, qb, lb);
    join
    fork
      i_ua.acc(0, 0, 16'h0003, 72'h0, 8'hFF, qa, la);
      i_ub.acc(1, 0, 16'h0003, 72'h0, 8'hFF, qb, lb);
    join
    chk("wide_lo", pat(9'h011), qa);
    chk("wide_hi", mrg(pat(9'h111), pat(9'h122), 16'h0081), qb);
    $display("test wide done");
    // clear acts at once and spares the array
    bus(1'b1, 4'h0, 32'h0000_046C, 4'hF, rq);
    i_ua.acc(1, 0, 16'h0005, 72'h0, 8'hFF, qa, la);
    i_ub.acc(1, 0, 16'h0005, 72'h0, 8'hFF, qb, lb);
    @(posedge clk_i);
    clr_a_i <= 1'b1;
    #1;
    chk("clr_a", 0, dout_a_o);
    chk("keep_b", m, dout_b_o);
    @(posedge clk_i);
    clr_a_i <= 1'b0;
    clr_b_i <= 1'b1;
    #1;
    chk("clr_b", 0, dout_b_o);
    @(posedge clk_i);
    clr_b_i <= 1'b0;
    i_ua.acc(1, 0, 16'h0005, 72'h0, 8'hFF, qa, la);
    chk("after_clr", m, qa);
    $display("test clear done");
    results;
  end
endmodule // drpm_top_test
